// ### hdl/pix_out_pkg.sv
// Shared constants, register map and types for the parallel video output block.
package pix_out_pkg;

  // Data path widths.
  localparam int DATA_W = 12;
  localparam int LOW_W  = 10;
  localparam int WORD_W = DATA_W + 2;
  localparam int FIFO_DEPTH = 2;

  // Positions inside the buffered word.
  localparam int WD_LINE  = 12;
  localparam int WD_FRAME = 13;

  // Positions inside the synchronised pin vector.
  localparam int SV_MODE  = 0;
  localparam int SV_GP    = 2;
  localparam int SV_PIX   = 4;
  localparam int SV_LINE  = 16;
  localparam int SV_FRAME = 17;
  localparam int SV_CLK   = 18;
  localparam int SV_W     = 19;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DIV    = 8'h08;

  // Control register fields.
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_EDGE = 1;
  localparam int CTRL_DIR  = 2;
  localparam int CTRL_GVAL = 4;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // Status register fields.
  localparam int ST_MODE  = 0;
  localparam int ST_GP    = 2;
  localparam int ST_LVIOL = 4;
  localparam int ST_FVIOL = 5;
  localparam int ST_LEVEL = 6;

  // Half period of the pixel clock in system clock cycles.
  localparam logic [7:0] DIV_RESET = 8'h0a;
  localparam logic [7:0] DIV_MIN   = 8'h01;

  // Sync toggles in 10-bit mode must be at least this many pixels apart.
  localparam int SYNC_WINDOW = 10;
  localparam logic [3:0] GAP_MIN = 4'(SYNC_WINDOW - 1);
  localparam logic [3:0] GAP_MAX = 4'h f;

  // Inactive upper outputs in 10-bit mode.
  localparam logic [1:0] UPPER_IDLE = 2'h0;

  // Mode pin decode; both codes with the high bit set select 10-bit mode.
  typedef enum logic [1:0] {
    MODE_LF12 = 2'b00,
    MODE_HF12 = 2'b01,
    MODE_10B  = 2'b10
  } mode_type;

  // Pixel clock phase, Gray coded along stop, low, high.
  typedef enum logic [1:0] {
    PH_STOP = 2'b00,
    PH_LOW  = 2'b01,
    PH_HIGH = 2'b11
  } phase_type;

endpackage

// ### hdl/pin_sync.sv
// Three-stage input synchroniser with agreement filter for pins from other domains.
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  if (WIDTH < 1) begin : g_check
    $error("pin_sync needs a width of at least one.");
  end

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sync_type;

  sync_type st;
  sync_type next_st;

  // A bit changes only once stages two and three agree, so a single late sample is ignored.
  always_comb begin
    next_st    = st;
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.q  = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.q);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.q;

endmodule

// ### hdl/pix_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/10ps
module pix_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 2
) (
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       in_valid_in,
  output logic                            in_ready_out,
  input  wire logic [WIDTH-1:0]           in_data_in,
  output logic                            out_valid_out,
  input  wire logic                       out_ready_in,
  output logic      [WIDTH-1:0]           out_data_out,
  output logic      [$clog2(DEPTH+1)-1:0] level_out
);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_check
    $error("pix_fifo depth must be a power of two, two or more.");
  end

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               count;
  } fifo_type;

  fifo_type st;
  fifo_type next_st;
  logic     push;
  logic     pop;

  // Full and empty come straight from the count, so neither side is ever lied to.
  assign in_ready_out  = st.count != CW'(DEPTH);
  assign out_valid_out = st.count != '0;
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data_in;
      next_st.wp         = st.wp + PW'(1);
    end
    if (pop) begin
      next_st.rp = st.rp + PW'(1);
    end
    next_st.count = st.count + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_data_out = st.mem[st.rp];
  assign level_out    = st.count;

endmodule

// ### hdl/par_video_out.sv
// Parallel video output stage of a serial-link deserializer with register slave.
//
// Behaviour
// [R1] 10-bit mode drives data on bits 9..0 only.
// [R2] 12-bit modes drive data on all twelve bits.
// [R3] Source toggles line sync once per ten pixels.
// [R4] Source toggles frame sync once per ten pixels.
// [R5] 12-bit modes pass line sync raw.
// [R6] 12-bit modes pass frame sync raw.
// [R7] Register bit selects pixel clock strobe edge.
// [R8] Input-configured general pins forward to remote outputs.
// [R9] Output-configured general pins drive local register value.
// [R10] Mode comes from the mode-select pin.
// [R11] Data and syncs change together, stable at strobe.
// [R12] Unused upper bits stay constant in 10-bit mode.
`timescale 1ns/10ps
module par_video_out (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        link_clk_in,
  input  wire logic [11:0] link_pixel_in,
  input  wire logic        link_line_sync_in,
  input  wire logic        link_frame_sync_in,
  output logic             link_ready_out,
  input  wire logic [1:0]  mode_sel_in,
  output logic      [11:0] par_pixel_out,
  output logic             line_sync_out,
  output logic             frame_sync_out,
  output logic             pclk_out,
  output logic             pix_valid_out,
  input  wire logic        pix_ready_in,
  input  wire logic [1:0]  gp_pins_low_in,
  output logic      [1:0]  gp_pins_low_out,
  output logic      [1:0]  gp_pins_low_oe_out,
  output logic      [1:0]  remote_gp_output_out
);

  localparam int LW = $clog2(pix_out_pkg::FIFO_DEPTH + 1);

  typedef struct packed {
    pix_out_pkg::phase_type          ph;
    logic [7:0]                      div_cnt;
    logic [7:0]                      half;
    logic                            run;
    logic                            edge_sel;
    logic [1:0]                      gdir;
    logic [1:0]                      gval;
    logic                            lclk_q;
    logic [pix_out_pkg::DATA_W-1:0]  pixel;
    logic                            lsync;
    logic                            fsync;
    logic                            valid;
    logic [1:0][3:0]                 gap;
    logic [1:0]                      viol;
    logic [1:0]                      remote;
    logic                            ahb_wr;
    logic [7:0]                      ahb_addr;
    logic [31:0]                     rdata;
  } state_type;

  state_type                        st;
  state_type                        next_st;
  logic [pix_out_pkg::SV_W-1:0]     pins;
  logic [pix_out_pkg::SV_W-1:0]     pins_sync;
  logic [pix_out_pkg::WORD_W-1:0]   fifo_in;
  logic [pix_out_pkg::WORD_W-1:0]   fifo_data;
  logic                             fifo_valid;
  logic [LW-1:0]                    fifo_level;
  logic                             link_rise;
  logic                             tick;
  logic                             launch;
  logic                             pop;
  logic                             mode10;
  logic [1:0]                       mode_now;
  logic [1:0]                       gp_sync;
  logic [1:0]                       sync_new;
  logic [1:0]                       sync_old;
  logic [1:0]                       w1c;
  logic                             addr_phase;

  // Every pin from outside the clock domain shares one filtered synchroniser.
  assign pins = {link_clk_in, link_frame_sync_in, link_line_sync_in,
                 link_pixel_in, gp_pins_low_in, mode_sel_in};

  pin_sync #(
    .WIDTH (pix_out_pkg::SV_W)
  ) u_sync (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .pin_in    (pins),
    .level_out (pins_sync)
  );

  // The link word is taken on the filtered rising edge of the link clock.
  // Words arriving while the buffer is full are refused; link_ready_out tells the source.
  assign link_rise = pins_sync[pix_out_pkg::SV_CLK] && !st.lclk_q;
  assign fifo_in   = {pins_sync[pix_out_pkg::SV_FRAME], pins_sync[pix_out_pkg::SV_LINE],
                      pins_sync[pix_out_pkg::SV_PIX +: pix_out_pkg::DATA_W]};

  pix_fifo #(
    .WIDTH (pix_out_pkg::WORD_W),
    .DEPTH (pix_out_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (link_rise),
    .in_ready_out  (link_ready_out),
    .in_data_in    (fifo_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (pop),
    .out_data_out  (fifo_data),
    .level_out     (fifo_level)
  );

  // Mode decode from the pin; codes 2 and 3 both mean 10-bit.
  assign mode_now = pins_sync[pix_out_pkg::SV_MODE +: 2];
  assign mode10   = mode_now[1]; // [R10]
  assign gp_sync  = pins_sync[pix_out_pkg::SV_GP +: 2];

  // Half-period divider; tick is a one-cycle enable and the pixel clock is a level decoded from the phase, not a second clock.
  assign tick   = st.ph != pix_out_pkg::PH_STOP && st.div_cnt >= st.half - 8'h01;
  // A launch is the move into the low phase, away from the strobe edge.
  assign launch = (st.ph == pix_out_pkg::PH_STOP && st.run) ||
                  (st.ph == pix_out_pkg::PH_HIGH && tick && st.run);
  assign pop    = launch && fifo_valid && pix_ready_in;

  assign sync_new = {fifo_data[pix_out_pkg::WD_FRAME], fifo_data[pix_out_pkg::WD_LINE]};
  assign sync_old = {st.fsync, st.lsync};

  assign addr_phase = hsel_in && hready_in && htrans_in[1];
  assign w1c = (st.ahb_wr && st.ahb_addr == pix_out_pkg::ADDR_STATUS) ?
               {hwdata_in[pix_out_pkg::ST_FVIOL], hwdata_in[pix_out_pkg::ST_LVIOL]} : 2'b00;

  // Next-state logic for the whole block.
  always_comb begin
    next_st        = st;
    next_st.lclk_q = pins_sync[pix_out_pkg::SV_CLK];

    // Phase sequencing: low then high, leaving only at the end of a high phase.
    next_st.div_cnt = tick ? 8'h00 : st.div_cnt + 8'h01;
    case (st.ph)
      pix_out_pkg::PH_STOP: begin
        next_st.div_cnt = 8'h00;
        if (st.run) begin
          next_st.ph = pix_out_pkg::PH_LOW;
        end
      end
      pix_out_pkg::PH_LOW: begin
        if (tick) begin
          next_st.ph = pix_out_pkg::PH_HIGH;
        end
      end
      pix_out_pkg::PH_HIGH: begin
        if (tick) begin
          next_st.ph = st.run ? pix_out_pkg::PH_LOW : pix_out_pkg::PH_STOP;
        end
      end
      default: begin
        next_st.ph = pix_out_pkg::PH_STOP;
      end
    endcase

    // Pixel, line and frame sync are loaded in one step at a launch. // [R11]
    if (launch) begin
      next_st.valid = pop;
    end
    if (pop) begin
      next_st.pixel = fifo_data[pix_out_pkg::DATA_W-1:0]; // [R2]
      if (mode10) begin // [R12]
        next_st.pixel[pix_out_pkg::DATA_W-1:pix_out_pkg::LOW_W] = pix_out_pkg::UPPER_IDLE; // [R1]
      end
      next_st.lsync = sync_new[0]; // [R5]
      next_st.fsync = sync_new[1]; // [R6]
    end

    // Sync spacing watch; the source owns the limit, this only reports it.
    // The clear is applied first, so a violation in the same cycle wins over it.
    for (int i = 0; i < 2; i++) begin
      if (w1c[i]) begin
        next_st.viol[i] = 1'b0;
      end
      if (pop && sync_new[i] != sync_old[i]) begin
        next_st.gap[i] = 4'h0;
        if (mode10 && st.gap[i] < pix_out_pkg::GAP_MIN) begin
          next_st.viol[i] = 1'b1; // [R3]
        end
      end else if (pop && st.gap[i] != pix_out_pkg::GAP_MAX) begin
        next_st.gap[i] = st.gap[i] + 4'h1;
      end
    end

    // General pins in input role forward their level across the link. // [R8]
    next_st.remote = gp_sync & ~st.gdir;

    // Register writes land in the data phase.
    if (st.ahb_wr && st.ahb_addr == pix_out_pkg::ADDR_CTRL) begin
      next_st.run      = hwdata_in[pix_out_pkg::CTRL_RUN];
      next_st.edge_sel = hwdata_in[pix_out_pkg::CTRL_EDGE];
      next_st.gdir     = hwdata_in[pix_out_pkg::CTRL_DIR +: 2];
      next_st.gval     = hwdata_in[pix_out_pkg::CTRL_GVAL +: 2];
    end
    if (st.ahb_wr && st.ahb_addr == pix_out_pkg::ADDR_DIV) begin
      next_st.half = (hwdata_in[7:0] == 8'h00) ? pix_out_pkg::DIV_MIN : hwdata_in[7:0];
    end

    // Address phase; read data is built from next values so a write just before is seen.
    next_st.ahb_wr = addr_phase && hwrite_in;
    if (addr_phase) begin
      next_st.ahb_addr = haddr_in[7:0];
    end
    if (addr_phase && !hwrite_in) begin
      next_st.rdata = 32'h0000_0000;
      case (haddr_in[7:0])
        pix_out_pkg::ADDR_CTRL: begin
          next_st.rdata[pix_out_pkg::CTRL_RUN]       = next_st.run;
          next_st.rdata[pix_out_pkg::CTRL_EDGE]      = next_st.edge_sel;
          next_st.rdata[pix_out_pkg::CTRL_DIR +: 2]  = next_st.gdir;
          next_st.rdata[pix_out_pkg::CTRL_GVAL +: 2] = next_st.gval;
        end
        pix_out_pkg::ADDR_STATUS: begin
          next_st.rdata[pix_out_pkg::ST_MODE +: 2]   = mode_now;
          next_st.rdata[pix_out_pkg::ST_GP +: 2]     = gp_sync;
          next_st.rdata[pix_out_pkg::ST_LVIOL]       = next_st.viol[0];
          next_st.rdata[pix_out_pkg::ST_FVIOL]       = next_st.viol[1];
          next_st.rdata[pix_out_pkg::ST_LEVEL +: LW] = fifo_level;
        end
        pix_out_pkg::ADDR_DIV: begin
          next_st.rdata[7:0] = next_st.half;
        end
        default: begin
          next_st.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st          <= '0;
      st.ph       <= pix_out_pkg::PH_STOP;
      st.half     <= pix_out_pkg::DIV_RESET;
      st.run      <= pix_out_pkg::CTRL_RESET[pix_out_pkg::CTRL_RUN];
      st.edge_sel <= pix_out_pkg::CTRL_RESET[pix_out_pkg::CTRL_EDGE];
      st.gap      <= {pix_out_pkg::GAP_MAX, pix_out_pkg::GAP_MAX};
    end else begin
      st <= next_st;
    end
  end

  // Zero-wait slave that always answers OKAY.
  assign hrdata_out    = st.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  // Outputs come from flip-flops; the strobe edge is picked by inverting the phase. // [R7]
  assign par_pixel_out        = st.pixel;
  assign line_sync_out        = st.lsync;
  assign frame_sync_out       = st.fsync;
  assign pix_valid_out        = st.valid;
  assign pclk_out             = (st.ph == pix_out_pkg::PH_HIGH) ^ st.edge_sel;
  assign gp_pins_low_oe_out   = st.gdir; // [R9]
  assign gp_pins_low_out      = st.gval; // [R9]
  assign remote_gp_output_out = st.remote;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_upper_bits_low: assert property ( // [R1]
    (pop && mode10) |=> par_pixel_out[11:10] == pix_out_pkg::UPPER_IDLE)
    else $error("Upper data bits loaded in 10-bit mode.");

  a_upper_bits_still: assert property ( // [R12]
    (mode10 && $past(mode10) && $past(par_pixel_out[11:10]) == pix_out_pkg::UPPER_IDLE)
    |-> par_pixel_out[11:10] == pix_out_pkg::UPPER_IDLE)
    else $error("Upper data bits toggled in 10-bit mode.");

  a_full_width_data: assert property ( // [R2]
    (pop && !mode10) |=> par_pixel_out == $past(fifo_data[11:0]))
    else $error("Twelve-bit word not passed whole.");

  a_line_sync_raw: assert property ( // [R5]
    (pop && !mode10) |=> line_sync_out == $past(fifo_data[pix_out_pkg::WD_LINE]))
    else $error("Line sync not passed raw.");

  a_frame_sync_raw: assert property ( // [R6]
    (pop && !mode10) |=> frame_sync_out == $past(fifo_data[pix_out_pkg::WD_FRAME]))
    else $error("Frame sync not passed raw.");

  a_strobe_edge_hold: assert property ( // [R7]
    ($changed(pclk_out) && pclk_out != st.edge_sel && $stable(st.edge_sel))
    |-> $stable(par_pixel_out) && $stable(line_sync_out) && $stable(frame_sync_out))
    else $error("Data moved on the strobe edge.");

  a_data_high_stable: assert property ( // [R11]
    (st.ph == pix_out_pkg::PH_HIGH && !launch)
    |=> $stable(par_pixel_out) && $stable(line_sync_out) && $stable(frame_sync_out))
    else $error("Data moved after the strobe edge.");

  a_gp_forward_level: assert property ( // [R8]
    (st.gdir == 2'b00 && $stable(gp_pins_low_in)) [*6] |-> remote_gp_output_out == gp_pins_low_in)
    else $error("Input general pin not forwarded.");

  a_line_gap_flag: assert property ( // [R3]
    (pop && mode10 && sync_new[0] != sync_old[0] && st.gap[0] < pix_out_pkg::GAP_MIN)
    |=> st.viol[0] [*2])
    else $error("Close line sync toggles not flagged.");

endmodule

// ### tb/video_sink_model.sv
// Behavioural video processor that captures pixels at the selected strobe edge.
`timescale 1ns/10ps
module video_sink_model (
  input  wire logic        clk_in,
  input  wire logic        pclk_in,
  input  wire logic        edge_sel_in,
  input  wire logic        stall_in,
  input  wire logic        valid_in,
  input  wire logic [11:0] data_in,
  input  wire logic        line_in,
  input  wire logic        frame_in,
  output logic             ready_out,
  output logic      [13:0] word_out,
  output logic      [7:0]  count_out,
  output logic      [7:0]  bad_out
);
  logic        pclk_d;
  logic [13:0] prev;

  // A stalled processor refuses the pixel offered at the next launch.
  assign ready_out = !stall_in;

  initial begin
    pclk_d    = 1'b0;
    prev      = 14'h0000;
    word_out  = 14'h0000;
    count_out = 8'h00;
    bad_out   = 8'h00;
  end

  // Capture on the strobe edge; a word that moves at that very edge would be misread.
  always @(posedge clk_in) begin
    pclk_d <= pclk_in;
    prev   <= {frame_in, line_in, data_in};
    if (pclk_in != pclk_d && pclk_in == !edge_sel_in && valid_in) begin
      word_out  <= {frame_in, line_in, data_in};
      count_out <= count_out + 8'h01;
      if (prev != {frame_in, line_in, data_in}) begin
        bad_out <= bad_out + 8'h01;
      end
    end
  end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the parallel video output block.
`timescale 1ns/10ps
module tb_top;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic        clk_in;
  logic        rst_n_in;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        link_clk;
  logic [11:0] link_pixel;
  logic        link_line;
  logic        link_frame;
  logic        link_ready;
  logic [1:0]  mode_sel;
  logic [11:0] par_pixel;
  logic        line_sync;
  logic        frame_sync;
  logic        pclk;
  logic        pix_valid;
  logic        pix_ready;
  logic [1:0]  gp_drv;
  logic [1:0]  gp_wire;
  logic [1:0]  gp_out;
  logic [1:0]  gp_oe;
  logic [1:0]  remote_gp;
  logic        edge_sel;
  logic        stall;
  logic [13:0] got_word;
  logic [7:0]  got_count;
  logic [7:0]  got_bad;
  logic [31:0] rd;
  int          n_fail;
  int          total_checks;

  // Each general pin carries the block's level while it drives, else the bench's.
  assign gp_wire = (gp_oe & gp_out) | (~gp_oe & gp_drv);

  always #2 clk_in = ~clk_in;

  par_video_out u_par_video_out (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(1'b1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
    .hresp_out(hresp), .link_clk_in(link_clk), .link_pixel_in(link_pixel),
    .link_line_sync_in(link_line), .link_frame_sync_in(link_frame),
    .link_ready_out(link_ready), .mode_sel_in(mode_sel), .par_pixel_out(par_pixel),
    .line_sync_out(line_sync), .frame_sync_out(frame_sync), .pclk_out(pclk),
    .pix_valid_out(pix_valid), .pix_ready_in(pix_ready), .gp_pins_low_in(gp_wire),
    .gp_pins_low_out(gp_out), .gp_pins_low_oe_out(gp_oe),
    .remote_gp_output_out(remote_gp));

  video_sink_model u_video_sink_model (
    .clk_in(clk_in), .pclk_in(pclk), .edge_sel_in(edge_sel), .stall_in(stall),
    .valid_in(pix_valid), .data_in(par_pixel), .line_in(line_sync),
    .frame_in(frame_sync), .ready_out(pix_ready), .word_out(got_word),
    .count_out(got_count), .bad_out(got_bad));

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_up();
    n_fail++;
    $display("unexpected at %0t: wait ran out", $time);
    report_and_stop();
  endtask

  // The slave never stretches a phase; the bound only guards against a hang.
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      give_up();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  // One link word per call; data stands well before and after the link clock rise.
  task automatic send_word(input logic [11:0] px, input logic ls, input logic fs);
    @(posedge clk_in);
    link_pixel <= px;
    link_line  <= ls;
    link_frame <= fs;
    #31.3 link_clk = 1'b1;
    #62.5 link_clk = 1'b0;
    #31.2;
  endtask

  task automatic wait_count(input logic [7:0] target);
    int n;
    n = 0;
    while (got_count !== target && n < 500) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 500) begin
      give_up();
    end
  endtask

  task automatic pass_word(input logic [11:0] px, input logic ls, input logic fs,
                           input logic [13:0] exp);
    logic [7:0] base;
    base = got_count;
    send_word(px, ls, fs);
    wait_count(base + 8'h01);
    check(got_word, exp);
  endtask

  task automatic test_registers();
    check(link_ready, 1'b1);
    check(gp_oe, 2'b00);
    check(hresp, 1'b0);
    bus(1'b0, pix_out_pkg::ADDR_CTRL, ZERO);
    check(rd, ZERO);
    bus(1'b0, pix_out_pkg::ADDR_DIV, ZERO);
    check(rd, {24'h00_0000, pix_out_pkg::DIV_RESET});
    bus(1'b1, pix_out_pkg::ADDR_DIV, ZERO);
    bus(1'b0, pix_out_pkg::ADDR_DIV, ZERO);
    check(rd, {24'h00_0000, pix_out_pkg::DIV_MIN});
    bus(1'b1, 8'h0c, 32'h0000_00ff);
    bus(1'b0, 8'h0c, ZERO);
    check(rd, ZERO);
    bus(1'b1, pix_out_pkg::ADDR_DIV, 32'h0000_0002);
  endtask

  // Every mode code, each with the strobe edge chosen by its low bit, and back-to-back sync toggles.
  task automatic test_modes();
    logic [1:0]  m;
    logic [11:0] mask;
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      mask = m[1] ? 12'h03ff : 12'h0fff;
      mode_sel <= m;
      edge_sel <= m[0];
      bus(1'b1, pix_out_pkg::ADDR_CTRL, {30'h0000_0000, m[0], 1'b1});
      repeat (8) @(posedge clk_in);
      bus(1'b0, pix_out_pkg::ADDR_STATUS, ZERO);
      check(rd[1:0], m);
      pass_word(12'h0fff, 1'b1, 1'b1, {2'b11, mask});
      pass_word(12'h0a5c, 1'b0, 1'b0, {2'b00, 12'h0a5c & mask});
      check(got_bad, 8'h00);
      bus(1'b0, pix_out_pkg::ADDR_STATUS, ZERO);
      check(rd[5:4], m[1] ? 2'b11 : 2'b00);
      bus(1'b1, pix_out_pkg::ADDR_STATUS, 32'h0000_0030);
      bus(1'b0, pix_out_pkg::ADDR_STATUS, ZERO);
      check(rd[5:4], 2'b00);
      bus(1'b1, pix_out_pkg::ADDR_CTRL, {30'h0000_0000, m[0], 1'b0});
      repeat (8) @(posedge clk_in);
      check(pclk, m[0]);
    end
  endtask

  // Fill the buffer behind a stalled processor, lose one word, then drain.
  task automatic test_buffer();
    logic [7:0] base;
    bus(1'b1, pix_out_pkg::ADDR_CTRL, 32'h0000_0003);
    stall <= 1'b1;
    base = got_count;
    send_word(12'h0111, 1'b0, 1'b0);
    send_word(12'h0222, 1'b0, 1'b0);
    check(link_ready, 1'b0);
    send_word(12'h0333, 1'b0, 1'b0);
    bus(1'b0, pix_out_pkg::ADDR_STATUS, ZERO);
    check(rd[7:6], 2'b10);
    stall <= 1'b0;
    wait_count(base + 8'h01);
    check(got_word, 14'h0111);
    wait_count(base + 8'h02);
    check(got_word, 14'h0222);
    repeat (40) @(posedge clk_in);
    check(got_count, base + 8'h02);
    bus(1'b0, pix_out_pkg::ADDR_STATUS, ZERO);
    check(rd[7:6], 2'b00);
    check(link_ready, 1'b1);
  endtask

  // Each pin once as output and once as input; a driven pin is never forwarded.
  task automatic test_gp();
    bus(1'b1, pix_out_pkg::ADDR_CTRL, 32'h0000_0034);
    gp_drv <= 2'b10;
    repeat (10) @(posedge clk_in);
    check(gp_oe, 2'b01);
    check(gp_out[0], 1'b1);
    check(remote_gp, 2'b10);
    bus(1'b0, pix_out_pkg::ADDR_STATUS, ZERO);
    check(rd[3:2], 2'b11);
    bus(1'b1, pix_out_pkg::ADDR_CTRL, 32'h0000_0028);
    gp_drv <= 2'b01;
    repeat (10) @(posedge clk_in);
    check(gp_oe, 2'b10);
    check(gp_out[1], 1'b1);
    check(remote_gp, 2'b01);
  endtask

  initial begin
    clk_in = 1'b0;
    rst_n_in = 1'b0;
    haddr = ZERO;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = ZERO;
    link_clk = 1'b0;
    link_pixel = 12'h000;
    link_line = 1'b0;
    link_frame = 1'b0;
    mode_sel = 2'b00;
    gp_drv = 2'b00;
    edge_sel = 1'b0;
    stall = 1'b0;
    n_fail = 0;
    total_checks = 0;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    test_registers();
    test_modes();
    test_buffer();
    test_gp();
    report_and_stop();
  end
endmodule
